// file: shared/lpw_pkg.sv
// Purpose: shared constants and types for the low-power wake controller
// Assumes: APB slave with 32-bit data, one word per register
// Notes:   vector values are the 16-bit addresses of the high byte of each pair

package lpw_pkg;

    // ==========================================================
    // register map
    localparam logic [7:0]  ADDR_CTRL       = 8'h00;
    localparam logic [7:0]  ADDR_STATUS     = 8'h04;
    localparam logic [7:0]  ADDR_VECTOR     = 8'h08;
    localparam int          CTRL_SHORT_BIT  = 0;
    localparam int          CTRL_EXTMASK_BIT = 1;
    localparam logic        CTRL_SHORT_RST  = 1'b0;
    localparam logic        CTRL_EXTMASK_RST = 1'b0;

    // ==========================================================
    // vector pairs
    localparam logic [15:0] VEC_RESET    = 16'hFFFE;
    localparam logic [15:0] VEC_BREAK    = 16'hFFFC;
    localparam logic [15:0] VEC_IRQ      = 16'hFFFA;
    localparam logic [15:0] VEC_CLKGEN   = 16'hFFF8;
    localparam logic [15:0] VEC_T1_CH0   = 16'hFFF6;
    localparam logic [15:0] VEC_T1_CH1   = 16'hFFF4;
    localparam logic [15:0] VEC_T1_OVF   = 16'hFFF2;
    localparam logic [15:0] VEC_T2_CH0   = 16'hFFF0;
    localparam logic [15:0] VEC_T2_OVF   = 16'hFFEC;
    localparam logic [15:0] VEC_SPI_RX   = 16'hFFEA;
    localparam logic [15:0] VEC_SPI_TX   = 16'hFFE8;
    localparam logic [15:0] VEC_SCI_ERR  = 16'hFFE6;
    localparam logic [15:0] VEC_SCI_RX   = 16'hFFE4;
    localparam logic [15:0] VEC_SCI_TX   = 16'hFFE2;
    localparam logic [15:0] VEC_KEYPAD   = 16'hFFE0;
    localparam logic [15:0] VEC_ADC      = 16'hFFDE;
    localparam logic [15:0] VEC_TIMEBASE = 16'hFFDC;

    // ==========================================================
    // stop recovery, in oscillator reference clock cycles
    localparam int          RECOVERY_WIDTH = 12;
    localparam int          RECOVERY_LONG  = 4096;
    localparam int          RECOVERY_SHORT = 32;
    localparam int          OSC_DIV        = 4;

    // ==========================================================
    // types
    typedef enum logic [3:0] {
        ST_RUN     = 4'b0001,
        ST_WAIT    = 4'b0010,
        ST_STOP    = 4'b0100,
        ST_RECOVER = 4'b1000
    } lp_state_t;

    typedef struct packed {
        logic break_req;
        logic clkgen;
        logic t1_ch0;
        logic t1_ch1;
        logic t1_ovf;
        logic t2_ch0;
        logic t2_ovf;
        logic spi_rx;
        logic spi_tx;
        logic sci_err;
        logic sci_rx;
        logic sci_tx;
        logic keypad;
        logic adc;
        logic timebase;
    } irq_req_t;

    typedef struct packed {
        lp_state_t   state;
        logic        cpu_clk_en;
        logic        sys_clk_en;
        logic        imask;
        logic        pc_load;
        logic [15:0] pc_vector;
        logic [15:0] pending_vec;
        logic        pending_reset;
        logic        reset_out;
        logic        irq_pin_prev;
        logic        short_sel;
        logic        ext_mask;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic        rec_start;
    } lpw_state_t;

endpackage

// file: logic/lpw_tick_divider.sv
// Purpose: one-cycle enable pulse at the oscillator reference rate
// Assumes: DIV of at least 2
// Notes:   pulse is registered

`timescale 1ns/10ps
`default_nettype none

module lpw_tick_divider #(
    parameter int DIV = 4
) (
    input  wire logic clk,
    input  wire logic reset_n,
    output var  logic tick
);

    typedef struct packed {
        logic [15:0] count;
        logic        tick;
    } div_state_t;

    div_state_t s_reg;
    div_state_t s_next;

    always_comb begin
        s_next      = s_reg;
        s_next.tick = 1'b0;
        if (s_reg.count == 16'(DIV - 1)) begin
            s_next.count = 16'h0000;
            s_next.tick  = 1'b1;
        end else begin
            s_next.count = s_reg.count + 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign tick = s_reg.tick;

endmodule // lpw_tick_divider

`default_nettype wire

// file: logic/lpw_recovery_counter.sv
// Purpose: stop recovery delay counter clocked by the oscillator tick
// Assumes: start is a one-cycle pulse; tick is a one-cycle enable
// Notes:   done pulses the cycle after the last counted tick

`timescale 1ns/10ps
`default_nettype none

module lpw_recovery_counter #(
    parameter int LONG_COUNT = lpw_pkg::RECOVERY_LONG
) (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic tick,
    input  wire logic start,
    input  wire logic short_sel,
    output var  logic busy,
    output var  logic done
);

    typedef struct packed {
        logic [lpw_pkg::RECOVERY_WIDTH-1:0] count;
        logic                               busy;
        logic                               done;
    } rec_state_t;

    rec_state_t s_reg;
    rec_state_t s_next;

    always_comb begin
        s_next      = s_reg;
        s_next.done = 1'b0;
        if (start) begin
            // short_sel is latched here so a late write cannot stretch the count
            s_next.busy  = 1'b1;
            s_next.count = short_sel
                ? lpw_pkg::RECOVERY_WIDTH'(lpw_pkg::RECOVERY_SHORT - 1)
                : lpw_pkg::RECOVERY_WIDTH'(LONG_COUNT - 1);
        end else if (s_reg.busy && tick) begin
            if (s_reg.count == '0) begin
                s_next.busy = 1'b0;
                s_next.done = 1'b1;
            end else begin
                s_next.count = s_reg.count - 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign busy = s_reg.busy;
    assign done = s_reg.done;

endmodule // lpw_recovery_counter

`default_nettype wire

// file: logic/low_power_wake_control.sv
// Purpose: wake control for the wait and stop low-power states
// Assumes: all inputs synchronous to CLK; WAIT_ENTER/STOP_ENTER are pulses
// Notes:   registers on APB; vector and clock enables are registered
//
// Notes on behaviour
// - in wait, a reset or enabled interrupt restarts CPU clock and loads a vector
// - external reset pin low resets and loads FFFE/FFFF from either low-power state
// - falling edge on external interrupt pin in wait wakes with vector FFFA
// - with emulation active, break wakes from wait or stop with vector FFFC
// - watchdog timeout in wait resets and loads vector FFFE
// - clock generator request in wait wakes with vector FFF8
// - keypad request in wait wakes with vector FFE0
// - timer one overflow FFF2, channel 1 FFF4, channel 0 FFF6 wake wait
// - timer two overflow FFEC and channel 0 FFF0 wake wait
// - serial peripheral transmit FFE8 and receive FFEA wake wait
// - async serial transmit FFE2, receive FFE4, receive error FFE6 wake wait
// - converter conversion complete wakes wait with vector FFDE
// - timebase request wakes wait with vector FFDC
// - stop exits only on reset pin, ext pin, keypad, low voltage, break, timebase
// - timebase rollover in stop gives periodic wake with vector FFDC
// - after stop exit the system clocks stay off for 4096 reference cycles
// - short recovery select cuts the stop recovery delay to 32 cycles
// - entering low power clears interrupt mask; reset wake sets, interrupt keeps clear
// - external pin wakes only while its wake mask bit is clear

`timescale 1ns/10ps
`default_nettype none

module low_power_wake_control #(
    parameter int RECOVERY_LONG_CYCLES = lpw_pkg::RECOVERY_LONG,
    parameter int OSC_DIV              = lpw_pkg::OSC_DIV
) (
    input  wire logic              CLK,
    input  wire logic              RESET_N,
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [7:0]        PADDR,
    input  wire logic [31:0]       PWDATA,
    output var  logic [31:0]       PRDATA,
    output var  logic              PREADY,
    output var  logic              PSLVERR,
    input  wire logic              WAIT_ENTER,
    input  wire logic              STOP_ENTER,
    input  wire logic              EXT_RESET_N,
    input  wire logic              EXT_IRQ_PIN,
    input  wire logic              EMULATION_MODE,
    input  wire logic              WDOG_TIMEOUT,
    input  wire logic              LVM_RESET,
    input  wire lpw_pkg::irq_req_t IRQ_REQ,
    output var  logic              CPU_CLK_EN,
    output var  logic              SYS_CLK_EN,
    output var  logic              CPU_IMASK,
    output var  logic              PC_LOAD,
    output var  logic [15:0]       PC_VECTOR,
    output var  logic              DEVICE_RESET
);

    // ==========================================================
    // vector selection, highest vector address wins
    function automatic logic [16:0] vector_pick(input lpw_pkg::irq_req_t r,
                                                input logic pin_ok);
        logic [16:0] v;
        v = 17'h00000;
        if (r.break_req)     v = {1'b1, lpw_pkg::VEC_BREAK};
        else if (pin_ok)     v = {1'b1, lpw_pkg::VEC_IRQ};
        else if (r.clkgen)   v = {1'b1, lpw_pkg::VEC_CLKGEN};
        else if (r.t1_ch0)   v = {1'b1, lpw_pkg::VEC_T1_CH0};
        else if (r.t1_ch1)   v = {1'b1, lpw_pkg::VEC_T1_CH1};
        else if (r.t1_ovf)   v = {1'b1, lpw_pkg::VEC_T1_OVF};
        else if (r.t2_ch0)   v = {1'b1, lpw_pkg::VEC_T2_CH0};
        else if (r.t2_ovf)   v = {1'b1, lpw_pkg::VEC_T2_OVF};
        else if (r.spi_rx)   v = {1'b1, lpw_pkg::VEC_SPI_RX};
        else if (r.spi_tx)   v = {1'b1, lpw_pkg::VEC_SPI_TX};
        else if (r.sci_err)  v = {1'b1, lpw_pkg::VEC_SCI_ERR};
        else if (r.sci_rx)   v = {1'b1, lpw_pkg::VEC_SCI_RX};
        else if (r.sci_tx)   v = {1'b1, lpw_pkg::VEC_SCI_TX};
        else if (r.keypad)   v = {1'b1, lpw_pkg::VEC_KEYPAD};
        else if (r.adc)      v = {1'b1, lpw_pkg::VEC_ADC};
        else if (r.timebase) v = {1'b1, lpw_pkg::VEC_TIMEBASE};
        return v;
    endfunction

    // ==========================================================
    // wake qualification
    lpw_pkg::lpw_state_t s_reg;
    lpw_pkg::lpw_state_t s_next;
    lpw_pkg::irq_req_t   req_wait;
    lpw_pkg::irq_req_t   req_stop;
    logic                irq_fall;
    logic                pin_ok;
    logic [16:0]         pick_wait;
    logic [16:0]         pick_stop;
    logic                reset_wait;
    logic                reset_stop;
    logic                osc_tick;
    logic                rec_busy;
    logic                rec_done;
    logic                apb_access;

    always_comb begin
        irq_fall           = s_reg.irq_pin_prev & ~EXT_IRQ_PIN;
        pin_ok             = irq_fall & ~s_reg.ext_mask;
        req_wait           = IRQ_REQ;
        req_wait.break_req = IRQ_REQ.break_req & EMULATION_MODE;
        // only these sources keep running while the clocks are stopped
        req_stop           = '0;
        req_stop.break_req = req_wait.break_req;
        req_stop.keypad    = IRQ_REQ.keypad;
        req_stop.timebase  = IRQ_REQ.timebase;
        pick_wait          = vector_pick(req_wait, pin_ok);
        pick_stop          = vector_pick(req_stop, pin_ok);
        reset_wait         = ~EXT_RESET_N | LVM_RESET | WDOG_TIMEOUT;
        // watchdog is unclocked in stop, so it cannot end it
        reset_stop         = ~EXT_RESET_N | LVM_RESET;
        apb_access         = PSEL & PENABLE;
    end

    lpw_tick_divider #(
        .DIV     (OSC_DIV)
    ) u_div (
        .clk     (CLK),
        .reset_n (RESET_N),
        .tick    (osc_tick)
    );

    lpw_recovery_counter #(
        .LONG_COUNT (RECOVERY_LONG_CYCLES)
    ) u_rec (
        .clk       (CLK),
        .reset_n   (RESET_N),
        .tick      (osc_tick),
        .start     (s_reg.rec_start),
        .short_sel (s_reg.short_sel),
        .busy      (rec_busy),
        .done      (rec_done)
    );

    // ==========================================================
    // state machine and register file
    always_comb begin
        s_next              = s_reg;
        s_next.pc_load      = 1'b0;
        s_next.reset_out    = 1'b0;
        s_next.rec_start    = 1'b0;
        s_next.irq_pin_prev = EXT_IRQ_PIN;
        unique case (s_reg.state)
            lpw_pkg::ST_RUN: begin
                if (reset_wait) begin
                    s_next.reset_out = 1'b1;
                    s_next.pc_load   = 1'b1;
                    s_next.pc_vector = lpw_pkg::VEC_RESET;
                    s_next.imask     = 1'b1;
                end else if (WAIT_ENTER) begin
                    s_next.state      = lpw_pkg::ST_WAIT;
                    s_next.cpu_clk_en = 1'b0;
                    s_next.imask      = 1'b0;
                end else if (STOP_ENTER) begin
                    s_next.state      = lpw_pkg::ST_STOP;
                    s_next.cpu_clk_en = 1'b0;
                    s_next.sys_clk_en = 1'b0;
                    s_next.imask      = 1'b0;
                end
            end
            lpw_pkg::ST_WAIT: begin
                if (reset_wait) begin
                    // reset is tested first so it wins over any interrupt
                    s_next.state      = lpw_pkg::ST_RUN;
                    s_next.cpu_clk_en = 1'b1;
                    s_next.reset_out  = 1'b1;
                    s_next.pc_load    = 1'b1;
                    s_next.pc_vector  = lpw_pkg::VEC_RESET;
                    s_next.imask      = 1'b1;
                end else if (pick_wait[16]) begin
                    s_next.state      = lpw_pkg::ST_RUN;
                    s_next.cpu_clk_en = 1'b1;
                    s_next.pc_load    = 1'b1;
                    s_next.pc_vector  = pick_wait[15:0];
                end
            end
            lpw_pkg::ST_STOP: begin
                if (reset_stop || pick_stop[16]) begin
                    s_next.state         = lpw_pkg::ST_RECOVER;
                    s_next.rec_start     = 1'b1;
                    s_next.pending_reset = reset_stop;
                    s_next.pending_vec   = reset_stop ? lpw_pkg::VEC_RESET
                                                      : pick_stop[15:0];
                end
            end
            lpw_pkg::ST_RECOVER: begin
                if (reset_stop) begin
                    s_next.pending_reset = 1'b1;
                    s_next.pending_vec   = lpw_pkg::VEC_RESET;
                end
                if (rec_done) begin
                    // clocks stay gated until the counter expires
                    s_next.state      = lpw_pkg::ST_RUN;
                    s_next.cpu_clk_en = 1'b1;
                    s_next.sys_clk_en = 1'b1;
                    s_next.pc_load    = 1'b1;
                    s_next.pc_vector  = reset_stop ? lpw_pkg::VEC_RESET : s_reg.pending_vec;
                    s_next.reset_out  = s_reg.pending_reset | reset_stop;
                    s_next.imask      = s_reg.pending_reset | reset_stop;
                end
            end
        endcase

        // apb: one wait state, answer registered
        s_next.pready  = 1'b0;
        s_next.pslverr = 1'b0;
        s_next.prdata  = 32'h00000000;
        if (apb_access && !s_reg.pready) begin
            s_next.pready = 1'b1;
            unique case (PADDR)
                lpw_pkg::ADDR_CTRL: begin
                    s_next.prdata[lpw_pkg::CTRL_SHORT_BIT]   = s_reg.short_sel;
                    s_next.prdata[lpw_pkg::CTRL_EXTMASK_BIT] = s_reg.ext_mask;
                end
                lpw_pkg::ADDR_STATUS: begin
                    s_next.prdata[7:0] = {s_reg.pending_reset, s_reg.imask, s_reg.sys_clk_en,
                                          s_reg.cpu_clk_en, s_reg.state};
                end
                lpw_pkg::ADDR_VECTOR: begin
                    s_next.prdata[15:0] = s_reg.pc_vector;
                end
                default: begin
                    s_next.pslverr = 1'b1;
                end
            endcase
        end
        if (apb_access && s_reg.pready && PWRITE && PADDR == lpw_pkg::ADDR_CTRL) begin
            s_next.short_sel = PWDATA[lpw_pkg::CTRL_SHORT_BIT];
            s_next.ext_mask  = PWDATA[lpw_pkg::CTRL_EXTMASK_BIT];
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            s_reg              <= '0;
            s_reg.state        <= lpw_pkg::ST_RUN;
            s_reg.cpu_clk_en   <= 1'b1;
            s_reg.sys_clk_en   <= 1'b1;
            s_reg.imask        <= 1'b1;
            s_reg.pc_vector    <= lpw_pkg::VEC_RESET;
            s_reg.irq_pin_prev <= 1'b1;
            s_reg.short_sel    <= lpw_pkg::CTRL_SHORT_RST;
            s_reg.ext_mask     <= lpw_pkg::CTRL_EXTMASK_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    assign PRDATA       = s_reg.prdata;
    assign PREADY       = s_reg.pready;
    assign PSLVERR      = s_reg.pslverr;
    assign CPU_CLK_EN   = s_reg.cpu_clk_en;
    assign SYS_CLK_EN   = s_reg.sys_clk_en;
    assign CPU_IMASK    = s_reg.imask;
    assign PC_LOAD      = s_reg.pc_load;
    assign PC_VECTOR    = s_reg.pc_vector;
    assign DEVICE_RESET = s_reg.reset_out;

    // ==========================================================
    // checks
    logic [12:0] tick_cnt;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            tick_cnt <= 13'h0000;
        end else if (s_reg.rec_start) begin
            tick_cnt <= 13'h0000;
        end else if (rec_busy && osc_tick) begin
            tick_cnt <= tick_cnt + 13'h0001;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    AST_WAIT_WAKE_RUNS: assert property (
        (s_reg.state == lpw_pkg::ST_WAIT) && (reset_wait || pick_wait[16])
        |=> CPU_CLK_EN && PC_LOAD && (s_reg.state == lpw_pkg::ST_RUN)
    ) else $error("wait wake did not restart cpu clock");

    AST_PIN_RESET_VEC: assert property (
        (s_reg.state == lpw_pkg::ST_WAIT) && !EXT_RESET_N
        |=> DEVICE_RESET && (PC_VECTOR == lpw_pkg::VEC_RESET)
    ) else $error("reset pin did not load reset vector");

    AST_IRQ_PIN_VEC: assert property (
        (s_reg.state == lpw_pkg::ST_WAIT) && !reset_wait && pin_ok && (IRQ_REQ == '0)
        |=> PC_LOAD && (PC_VECTOR == lpw_pkg::VEC_IRQ) && !DEVICE_RESET
    ) else $error("pin interrupt vector wrong");

    AST_BREAK_VEC: assert property (
        (s_reg.state == lpw_pkg::ST_WAIT) && !reset_wait && IRQ_REQ.break_req && EMULATION_MODE
        |=> PC_VECTOR == lpw_pkg::VEC_BREAK
    ) else $error("break vector wrong");

    AST_WDOG_RESET: assert property (
        (s_reg.state == lpw_pkg::ST_WAIT) && WDOG_TIMEOUT
        |=> DEVICE_RESET && CPU_IMASK && (PC_VECTOR == lpw_pkg::VEC_RESET)
    ) else $error("watchdog timeout did not reset");

    AST_WAIT_VEC_PICK: assert property (
        (s_reg.state == lpw_pkg::ST_WAIT) && !reset_wait && pick_wait[16]
        |=> PC_VECTOR == $past(pick_wait[15:0])
    ) else $error("wait wake vector does not match source");

    AST_STOP_IGNORES: assert property (
        (s_reg.state == lpw_pkg::ST_STOP) && !reset_stop && !pick_stop[16]
        |=> (s_reg.state == lpw_pkg::ST_STOP) && !SYS_CLK_EN
    ) else $error("stop left by a source that may not wake it");

    AST_TIMEBASE_STOP: assert property (
        (s_reg.state == lpw_pkg::ST_STOP) && !reset_stop && !pin_ok && (req_stop == '0 | IRQ_REQ.timebase)
        && IRQ_REQ.timebase && !IRQ_REQ.keypad && !req_wait.break_req
        |=> (s_reg.state == lpw_pkg::ST_RECOVER) && (s_reg.pending_vec == lpw_pkg::VEC_TIMEBASE)
    ) else $error("timebase did not start stop wake");

    AST_LONG_RECOVERY: assert property (
        rec_done && !s_reg.short_sel |-> tick_cnt == 13'(RECOVERY_LONG_CYCLES)
    ) else $error("long recovery count wrong");

    AST_SHORT_RECOVERY: assert property (
        rec_done && s_reg.short_sel |-> tick_cnt == 13'(lpw_pkg::RECOVERY_SHORT)
    ) else $error("short recovery count wrong");

    AST_CLOCKS_GATED: assert property (
        (s_reg.state == lpw_pkg::ST_RECOVER) && !rec_done |=> !SYS_CLK_EN && !CPU_CLK_EN
    ) else $error("system clocks ran during recovery");

    AST_IMASK_WAKE: assert property (
        PC_LOAD |-> (CPU_IMASK == DEVICE_RESET)
    ) else $error("interrupt mask wrong after wake");

    AST_IMASK_ENTRY: assert property (
        (s_reg.state == lpw_pkg::ST_WAIT) || (s_reg.state == lpw_pkg::ST_STOP) |-> !CPU_IMASK
    ) else $error("interrupt mask set in low power");

    AST_PIN_MASKED: assert property (
        (s_reg.state == lpw_pkg::ST_WAIT) && s_reg.ext_mask && !reset_wait && (IRQ_REQ == '0)
        |=> s_reg.state == lpw_pkg::ST_WAIT
    ) else $error("masked pin woke the core");

    AST_RESET_WINS: assert property (
        (s_reg.state == lpw_pkg::ST_WAIT) && reset_wait && pick_wait[16]
        |=> PC_VECTOR == lpw_pkg::VEC_RESET
    ) else $error("interrupt beat a reset");

    COV_WAIT_IRQ: cover property (
        (s_reg.state == lpw_pkg::ST_WAIT) && pin_ok ##1 PC_LOAD);
    COV_STOP_LONG: cover property (rec_done && !s_reg.short_sel);
    COV_STOP_SHORT: cover property (rec_done && s_reg.short_sel);
    COV_WAIT_RESET: cover property ((s_reg.state == lpw_pkg::ST_WAIT) && WDOG_TIMEOUT);

endmodule // low_power_wake_control

`default_nettype wire

// file: tb/lpw_core_model.sv
// Purpose: core side model that issues low-power entry pulses
// Assumes: requests change just after a rising edge
// Notes:   never raises both pulses in one cycle
`timescale 1ns/10ps
`default_nettype none
module lpw_core_model (
    input  wire logic clk,
    input  wire logic go_wait,
    input  wire logic go_stop,
    output var  logic wait_enter = 1'b0,
    output var  logic stop_enter = 1'b0
);
    // ==========
    // one pulse per request, like a retiring instruction
    always @(posedge clk) begin
        wait_enter <= go_wait;
        stop_enter <= go_stop & ~go_wait;
    end
endmodule // lpw_core_model
`default_nettype wire

// file: tb/test_low_power_wake_control.sv
// Purpose: random and corner tests of the wake controller
// Assumes: recovery shortened to 64 ticks, tick every 2 clocks
// Notes:   expected vectors come from a local table
`timescale 1ns/10ps
`default_nettype none
module test_low_power_wake_control;
    localparam int LONG = 64;
    localparam int DIV  = 2;
    logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, gw = 0, gs = 0;
    logic xr = 1, xi = 1, em = 1, wd = 0, lv = 0, we, se, prdy, perr, cpu, sys, im, pl, dr, er;
    logic [7:0] pa = 8'h00;
    logic [31:0] pwd = 32'h0, prd, rd, d;
    logic [15:0] pv;
    lpw_pkg::irq_req_t irq = '0;
    int err_total = 0, checks_done = 0, seed = 45, cyc = 0, i;
    logic [15:0] vt [15] = '{16'hFFDC, 16'hFFDE, 16'hFFE0, 16'hFFE2, 16'hFFE4,
        16'hFFE6, 16'hFFE8, 16'hFFEA, 16'hFFEC, 16'hFFF0, 16'hFFF2, 16'hFFF4,
        16'hFFF6, 16'hFFF8, 16'hFFFC};
    always #12.5 clk = ~clk;
    lpw_core_model core (.clk(clk), .go_wait(gw), .go_stop(gs), .wait_enter(we),
        .stop_enter(se));
    low_power_wake_control #(.RECOVERY_LONG_CYCLES(LONG), .OSC_DIV(DIV)) DUT (
        .CLK(clk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
        .PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr),
        .WAIT_ENTER(we), .STOP_ENTER(se), .EXT_RESET_N(xr), .EXT_IRQ_PIN(xi),
        .EMULATION_MODE(em), .WDOG_TIMEOUT(wd), .LVM_RESET(lv), .IRQ_REQ(irq),
        .CPU_CLK_EN(cpu), .SYS_CLK_EN(sys), .CPU_IMASK(im), .PC_LOAD(pl),
        .PC_VECTOR(pv), .DEVICE_RESET(dr));
    // ==========
    // shared tasks
    task automatic end_sim;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(logic [31:0] g, logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic apb(logic w, logic [7:0] a, logic [31:0] v);
        @(posedge clk);
        {psel, pen, pwr, pa, pwd} <= {2'b10, w, a, v};
        @(posedge clk);
        pen <= 1;
        do @(posedge clk); while (prdy !== 1'b1);
        rd = prd;
        er = perr;
        {psel, pen} <= 2'b00;
    endtask
    task automatic enter(logic stp);
        @(posedge clk);
        {gw, gs} <= {!stp, stp};
        @(posedge clk);
        {gw, gs} <= 2'b00;
        repeat (2) @(posedge clk);
        chk({cpu, sys, im}, {1'b0, !stp, 1'b0});
    endtask
    // waits for the vector load and checks it, the clocks, mask and timing
    task automatic wake(logic [15:0] ev, logic rs, int lo, int hi);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pl !== 1'b1 && n < 4000);
        chk(pv, ev);
        chk({cpu, sys, im, dr}, {2'b11, rs, rs});
        chk(n >= lo && n <= hi, 1);
        {irq, xi, xr, wd, lv, em} <= {15'h0, 5'b11001};
    endtask
    always @(posedge clk) if (++cyc > 6000) begin
        err_total++;
        end_sim();
    end
    // ==========
    // main sequence
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1;
        chk({im, pv}, 17'h1FFFE);
        d = $random(seed);
        apb(1, 8'h00, d);
        apb(0, 8'h00, 0);
        chk(rd, d & 32'h3);
        apb(0, 8'h0C, 0);
        chk(er, 1);
        apb(1, 8'h00, 0);
        for (i = 0; i < 15; i++) begin
            enter(0);
            irq <= 15'((1 << i) | ($random(seed) & ((1 << i) - 1)));
            wake(vt[i], 0, 2, 2);
        end
        // break is ignored outside emulation, so the converter wins
        enter(0);
        {em, irq} <= {1'b0, 15'h4002};
        wake(16'hFFDE, 0, 2, 2);
        enter(0);
        xi <= 0;
        wake(16'hFFFA, 0, 2, 2);
        enter(0);
        wd <= 1;
        wake(16'hFFFE, 1, 2, 2);
        enter(0);
        {xr, irq} <= {1'b0, 15'(($random(seed)))};
        wake(16'hFFFE, 1, 2, 2);
        apb(1, 8'h00, 32'h3);
        enter(0);
        xi <= 0;
        repeat (3) @(posedge clk);
        chk(pl, 0);
        irq <= 15'h2;
        wake(16'hFFDE, 0, 2, 2);
        apb(0, 8'h04, 0);
        chk(rd, 32'h00000031);
        apb(0, 8'h08, 0);
        chk(rd, 32'h0000FFDE);
        enter(1);
        // watchdog and clock generator may not end stop
        {wd, irq} <= {1'b1, 15'h2000};
        repeat (3) @(posedge clk);
        chk({pl, sys}, 2'b00);
        {wd, irq} <= {1'b0, 15'h2004};
        wake(16'hFFE0, 0, 32 * DIV, 32 * DIV + 9);
        apb(1, 8'h00, 0);
        enter(1);
        irq <= 15'h1;
        wake(16'hFFDC, 0, LONG * DIV, LONG * DIV + 9);
        enter(1);
        lv <= 1;
        wake(16'hFFFE, 1, LONG * DIV, LONG * DIV + 9);
        rst_n <= 0;
        @(posedge clk);
        chk({cpu, sys, im, pl, pv, dr}, {4'b1110, 16'hFFFE, 1'b0});
        rst_n <= 1;
        @(posedge clk);
        end_sim();
    end
endmodule // test_low_power_wake_control
`default_nettype wire
